// ### core/eeprom_io_access_port.sv
// nonvolatile byte store with its i/o register port and 8-bit temp byte
// How it works
// [R01] 1k byte store, byte-wide access via registers
// [R02] write self-timed, busy flag shows completion
// [R03] write launches only via unlock then strobe
// [R04] read trigger stalls cpu four cycles
// [R05] write trigger stalls cpu two cycles
// [R06] reset does not abort a running write
// [R07] low i/o bits settable, clearable, testable
// [R08] i/o address plus 0x20 gives data address
// [R09] extended range only through data space
// [R10] software writes reserved bits zero
// [R11] bit operations touch only the addressed bit
// [R12] three plain scratch bytes, one bit-accessible
// [R13] low write held in temp, high copies
// [R14] low read captures high into temp
// [R15] temp byte directly readable and writable
// [R16] software masks interrupts around 16-bit access
// [R17] address pair: low at base, high +1
// [R18] address pair at data 0x41, i/o 0x21
// [R19] unlock clears after four cycles, gates strobe
// [R20] mode field picks erase, write or both
// [R21] strobe clears when done, ready level follows
// [R22] busy write blocks reads and address writes
`timescale 1ns/1ps
module eeprom_io_access_port
  import eeprom_io_pkg::*;
#(
  parameter int unsigned ATOMIC_CYCLES = ATOMIC_TIME_NS / CLK_PERIOD_NS,
  parameter int unsigned SPLIT_CYCLES = SPLIT_TIME_NS / CLK_PERIOD_NS
) (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic POR_B,
  input wire logic [7:0] ADDR,
  input wire logic IO_SPACE,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [7:0] WDATA,
  input wire logic BIT_OP,
  input wire logic [2:0] BIT_SEL,
  input wire logic BIT_VAL,
  output logic [7:0] RDATA,
  output logic BIT_TEST,
  output logic ACC_ERR,
  output logic STALL,
  output logic WRITE_BUSY,
  output logic READY_IRQ
);

  localparam logic [TIMER_W-1:0] ATOMIC_CNT = TIMER_W'(ATOMIC_CYCLES);
  localparam logic [TIMER_W-1:0] SPLIT_CNT = TIMER_W'(SPLIT_CYCLES);

  // cpu-side register state, cleared by the core reset
  typedef struct packed {
    logic [1:0] pm;
    logic rie;
    logic mwe;
    logic [2:0] mwe_cnt;
    logic [2:0] stall;
    logic [7:0] data;
    logic [ADDR_W-1:0] addr;
    logic [7:0] temp;
    logic [7:0] scr0;
    logic [7:0] scr1;
    logic [7:0] scr2;
    logic [7:0] rdata;
    logic bitv;
    logic err;
  } cpu_t;

  // programming engine and store, reset only at power-on, with the store set to all ones (erased)
  typedef struct packed {
    logic busy;
    logic [TIMER_W-1:0] timer;
    logic [1:0] mode;
    logic [MEM_AW-1:0] paddr;
    logic [7:0] pdata;
    logic [MEM_BYTES-1:0][7:0] mem;
  } eng_t;

  cpu_t st;
  cpu_t next_st;
  eng_t eng;
  eng_t next_eng;

  logic hit;
  logic bit_ok;
  logic acc_ok;
  logic wr;
  logic rd;
  logic [7:0] da;
  logic [7:0] mask;
  logic [7:0] wmask;
  logic [7:0] cur;
  logic [7:0] wbyte;
  logic launch;
  logic rtrig;
  logic mwe_set;
  logic ctl_wr;

  // map an i/o or data-space address to {valid, data address}
  function automatic logic [8:0] map_addr(input logic io, input logic [7:0] a);
    logic [8:0] r;
    if (io) begin
      r = {a <= IO_TOP, 8'(a + IO_OFS)}; // [R08] [R09]
    end else begin
      r = {1'b1, a};
    end
    return r;
  endfunction

  // register read mux by data address
  function automatic logic [8:0] rd_mux(input logic [7:0] a, input cpu_t s,
                                        input logic busy);
    logic [8:0] r;
    r = 9'h000;
    unique case (a)
      DS_CTRL: r = {1'b1, 2'b00, s.pm, s.rie, s.mwe, busy, 1'b0}; // [R21]
      DS_DATA: r = {1'b1, s.data};
      DS_ADDR_LO: r = {1'b1, s.addr[7:0]}; // [R17] [R18]
      DS_ADDR_HI: r = {1'b1, s.temp}; // [R14]
      DS_SCR0: r = {1'b1, s.scr0}; // [R12]
      DS_SCR1: r = {1'b1, s.scr1}; // [R12]
      DS_SCR2: r = {1'b1, s.scr2}; // [R12]
      DS_TEMP: r = {1'b1, s.temp}; // [R15]
      default: r = 9'h000;
    endcase
    return r;
  endfunction

  // next-state logic for registers and engine
  always_comb begin
    logic [8:0] m;
    logic [8:0] q;
    m = map_addr(IO_SPACE, ADDR);
    q = rd_mux(m[7:0], st, eng.busy);
    next_st = st;
    next_eng = eng;
    launch = 1'b0;
    rtrig = 1'b0;
    mwe_set = 1'b0;
    ctl_wr = 1'b0;
    da = m[7:0];
    cur = q[7:0];
    bit_ok = !BIT_OP || (IO_SPACE && ADDR <= BIT_IO_TOP); // [R07]
    hit = m[8] && q[8];
    acc_ok = hit && bit_ok;
    wr = WR_EN && acc_ok;
    rd = RD_EN && acc_ok && !WR_EN;
    mask = 8'h01 << BIT_SEL;
    wmask = BIT_OP ? mask : 8'hff; // [R11]
    wbyte = BIT_OP ? (BIT_VAL ? (cur | mask) : (cur & ~mask)) : WDATA; // [R07]
    // unlock window countdown
    if (st.mwe) begin
      if (st.mwe_cnt == 3'h1) begin
        next_st.mwe = 1'b0; // [R19]
      end else begin
        next_st.mwe_cnt = st.mwe_cnt - 3'h1;
      end
    end
    // cpu stall countdown
    if (st.stall != 3'h0) begin
      next_st.stall = st.stall - 3'h1;
    end
    // self-timed programming engine
    if (eng.busy) begin
      next_eng.timer = eng.timer - TIMER_W'(1);
      if (eng.timer == TIMER_W'(1)) begin
        next_eng.busy = 1'b0; // [R02] [R21]
        unique case (eng.mode)
          MODE_ATOMIC: next_eng.mem[eng.paddr] = eng.pdata; // [R20]
          MODE_ERASE: next_eng.mem[eng.paddr] = ERASED; // [R20]
          MODE_WRITE: next_eng.mem[eng.paddr] = eng.mem[eng.paddr] & eng.pdata; // [R20]
          default: next_eng.mem[eng.paddr] = eng.mem[eng.paddr];
        endcase
      end
    end
    // register writes
    if (wr) begin
      unique case (da)
        DS_CTRL: begin
          ctl_wr = 1'b1;
          if (wmask[CTL_RIE]) begin
            next_st.rie = wbyte[CTL_RIE];
          end
          if (wmask[CTL_PM] && !eng.busy) begin
            next_st.pm[0] = wbyte[CTL_PM];
          end
          if (wmask[CTL_PM+1] && !eng.busy) begin
            next_st.pm[1] = wbyte[CTL_PM+1];
          end
          if (wmask[CTL_MWE]) begin
            next_st.mwe = wbyte[CTL_MWE];
            next_st.mwe_cnt = MWE_WINDOW;
            mwe_set = wbyte[CTL_MWE];
          end
          // strobe honoured only inside an open unlock window
          if (wmask[CTL_WS] && wbyte[CTL_WS] && st.mwe && !eng.busy) begin
            launch = 1'b1; // [R03] [R19]
            next_st.mwe = 1'b0;
            mwe_set = 1'b0; // launch consumes the window, no restart
            next_st.stall = WRITE_STALL; // [R05]
            next_eng.busy = 1'b1;
            next_eng.mode = next_st.pm; // [R20]
            next_eng.timer = (next_st.pm == MODE_ATOMIC) ? ATOMIC_CNT : SPLIT_CNT;
            next_eng.paddr = st.addr[MEM_AW-1:0];
            next_eng.pdata = st.data;
          end
          // read strobe gives the byte at once unless a write is busy
          if (wmask[CTL_RS] && wbyte[CTL_RS] && !eng.busy) begin
            rtrig = 1'b1; // [R22]
            next_st.data = eng.mem[st.addr[MEM_AW-1:0]]; // [R01]
            next_st.stall = READ_STALL; // [R04]
          end
        end
        DS_DATA: next_st.data = wbyte;
        DS_ADDR_LO: next_st.temp = wbyte; // [R13] [R18]
        DS_ADDR_HI: begin
          if (!eng.busy) begin
            next_st.addr = {wbyte[ADDR_W-9:0], st.temp}; // [R13] [R17] [R22]
          end
        end
        DS_SCR0: next_st.scr0 = wbyte; // [R11] [R12]
        DS_SCR1: next_st.scr1 = wbyte; // [R12]
        DS_SCR2: next_st.scr2 = wbyte; // [R12]
        DS_TEMP: next_st.temp = wbyte; // [R15]
        default: next_st.err = 1'b1;
      endcase
    end
    // register reads, with high-byte capture on low read
    if (rd) begin
      next_st.rdata = cur;
      next_st.bitv = |(cur & mask); // [R07]
      if (da == DS_ADDR_LO) begin
        next_st.temp = {{(16-ADDR_W){1'b0}}, st.addr[ADDR_W-1:8]}; // [R14]
      end
    end
    next_st.err = (WR_EN || RD_EN) && !acc_ok; // [R09]
  end

  // cpu-side registers
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st <= '{data: DATA_RST, default: '0};
    end else begin
      st <= next_st;
    end
  end

  // engine ignores core reset so a running write completes
  always_ff @(posedge CORE_CLK or negedge POR_B) begin
    if (!POR_B) begin
      eng <= '{mem: '1, default: '0};
    end else begin
      eng <= next_eng; // [R06]
    end
  end

  // outputs
  assign RDATA = st.rdata;
  assign BIT_TEST = st.bitv;
  assign ACC_ERR = st.err;
  assign STALL = st.stall != 3'h0; // [R04] [R05]
  assign WRITE_BUSY = eng.busy; // [R02]
  assign READY_IRQ = st.rie && !eng.busy; // [R21]

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B || !POR_B);

  // stall sequences
  sequence s_stall4;
    STALL [*4] ##1 !STALL;
  endsequence
  sequence s_stall2;
    STALL [*2] ##1 !STALL;
  endsequence

  property p_read_stall;
    rtrig |=> s_stall4;
  endproperty
  a_read_stall: assert property (p_read_stall) else $error("read stall wrong"); // [R04]

  property p_write_stall;
    launch |=> s_stall2;
  endproperty
  a_write_stall: assert property (p_write_stall) else $error("write stall wrong"); // [R05]

  // unlock window with no further control writes
  sequence s_mwe_quiet;
    mwe_set ##1 (!ctl_wr) [*4];
  endsequence
  property p_mwe_timeout;
    s_mwe_quiet |=> !st.mwe;
  endproperty
  a_mwe_timeout: assert property (p_mwe_timeout) else $error("unlock not timed out"); // [R19]

  property p_mwe_held;
    mwe_set ##1 (!ctl_wr) [*4] |-> st.mwe;
  endproperty
  a_mwe_held: assert property (p_mwe_held) else $error("unlock closed early"); // [R19]

  property p_no_unlock;
    ctl_wr && wmask[CTL_WS] && wbyte[CTL_WS] && !st.mwe && !eng.busy |=> !eng.busy;
  endproperty
  a_no_unlock: assert property (p_no_unlock) else $error("write without unlock"); // [R03]

  property p_addr_locked;
    wr && da == DS_ADDR_HI && eng.busy |=> $stable(st.addr);
  endproperty
  a_addr_locked: assert property (p_addr_locked) else $error("address changed while busy"); // [R22]

  property p_temp_low;
    wr && da == DS_ADDR_LO |=> st.temp == $past(wbyte);
  endproperty
  a_temp_low: assert property (p_temp_low) else $error("low byte not held"); // [R13]

  property p_temp_cap;
    rd && da == DS_ADDR_LO |=> st.temp == {4'h0, $past(st.addr[ADDR_W-1:8])};
  endproperty
  a_temp_cap: assert property (p_temp_cap) else $error("high byte not captured"); // [R14]

  property p_done_ready;
    eng.busy && eng.timer == TIMER_W'(1) && st.rie && !ctl_wr |=> READY_IRQ && !WRITE_BUSY;
  endproperty
  a_done_ready: assert property (p_done_ready) else $error("ready not raised"); // [R21]

  property p_bit_only;
    wr && BIT_OP && da == DS_SCR0 |=> (st.scr0 & ~$past(mask)) == ($past(st.scr0) & ~$past(mask));
  endproperty
  a_bit_only: assert property (p_bit_only) else $error("bit op touched others"); // [R11]

  property p_ext_io;
    (WR_EN || RD_EN) && IO_SPACE && ADDR > IO_TOP |=> ACC_ERR;
  endproperty
  a_ext_io: assert property (p_ext_io) else $error("i/o reached extended range"); // [R09]

endmodule

// ### core/eeprom_io_pkg.sv
// constants for the nonvolatile byte store and its i/o access port
package eeprom_io_pkg;
  // i/o to data space offset and range limits
  localparam logic [7:0] IO_OFS = 8'h20;
  localparam logic [7:0] IO_TOP = 8'h3f;
  localparam logic [7:0] BIT_IO_TOP = 8'h1f;
  // data-space register offsets
  localparam logic [7:0] DS_SCR0 = 8'h3e;
  localparam logic [7:0] DS_CTRL = 8'h3f;
  localparam logic [7:0] DS_DATA = 8'h40;
  localparam logic [7:0] DS_ADDR_LO = 8'h41;
  localparam logic [7:0] DS_ADDR_HI = 8'h42;
  localparam logic [7:0] DS_SCR1 = 8'h4a;
  localparam logic [7:0] DS_SCR2 = 8'h4b;
  localparam logic [7:0] DS_TEMP = 8'h60;
  // control register field positions
  localparam int CTL_RS = 0;
  localparam int CTL_WS = 1;
  localparam int CTL_MWE = 2;
  localparam int CTL_RIE = 3;
  localparam int CTL_PM = 4;
  // programming mode codes
  localparam logic [1:0] MODE_ATOMIC = 2'b00;
  localparam logic [1:0] MODE_ERASE = 2'b01;
  localparam logic [1:0] MODE_WRITE = 2'b10;
  // store geometry
  localparam int MEM_BYTES = 1024;
  localparam int MEM_AW = 10;
  localparam int ADDR_W = 12;
  localparam logic [7:0] ERASED = 8'hff;
  localparam logic [7:0] DATA_RST = 8'h00;
  // cycle counts
  localparam logic [2:0] MWE_WINDOW = 3'h4;
  localparam logic [2:0] READ_STALL = 3'h4;
  localparam logic [2:0] WRITE_STALL = 3'h2;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned ATOMIC_TIME_NS = 3400000;
  localparam int unsigned SPLIT_TIME_NS = 1800000;
  localparam int TIMER_W = 18;
endpackage

// ### test/cpu_core_model.sv
// cpu core model issuing one-cycle register reads and writes
`timescale 1ns/1ps
module cpu_core_model (
  input wire logic clk,
  output logic [7:0] addr,
  output logic io,
  output logic wr,
  output logic rd,
  output logic [7:0] wdata,
  output logic bit_op,
  output logic [2:0] bit_sel,
  output logic bit_val
);
  // idle bus at time zero
  initial begin
    {addr, io, wr, rd, wdata, bit_op, bit_sel, bit_val} = '0;
  end
  // request on a falling edge, released at the next; sequences never interrupted
  task automatic req(input logic w, input logic s, input logic [7:0] a, input logic [7:0] d,
      input logic b, input logic [2:0] n, input logic v);
    @(negedge clk);
    {wr, rd, io, addr, wdata, bit_op, bit_sel, bit_val} = {w, !w, s, a, d, b, n, v};
    @(negedge clk);
    {wr, rd, bit_op} = '0;
    addr = ~addr;
    wdata = ~wdata;
  endtask
endmodule

// ### test/eeprom_io_access_port_bench.sv
// self-checking bench for the nonvolatile byte store port
`timescale 1ns/1ps
module eeprom_io_access_port_bench;
  import eeprom_io_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic por_b = 1'b0;
  logic [7:0] addr, wdata, rdata, d, v;
  logic io, wr_en, rd_en, bit_op, bit_val, bit_test, acc_err, stall, busy, irq;
  logic [2:0] bit_sel;
  logic [7:0] sa [3] = '{DS_SCR0, DS_SCR1, DS_SCR2};
  logic [7:0] ctl = DS_CTRL - IO_OFS;
  logic [7:0] store [1024];
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int i, k, n, a;
  // clock
  always #12.5 clk = ~clk;
  cpu_core_model cpu (.clk(clk), .addr(addr), .io(io), .wr(wr_en), .rd(rd_en), .wdata(wdata),
    .bit_op(bit_op), .bit_sel(bit_sel), .bit_val(bit_val));
  eeprom_io_access_port #(.ATOMIC_CYCLES(20), .SPLIT_CYCLES(10)) i_eeprom_io_access_port (
    .CORE_CLK(clk), .RST_B(rst_b), .POR_B(por_b), .ADDR(addr), .IO_SPACE(io), .WR_EN(wr_en),
    .RD_EN(rd_en), .WDATA(wdata), .BIT_OP(bit_op), .BIT_SEL(bit_sel), .BIT_VAL(bit_val),
    .RDATA(rdata), .BIT_TEST(bit_test), .ACC_ERR(acc_err), .STALL(stall),
    .WRITE_BUSY(busy), .READY_IRQ(irq));
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      conclude();
    end
  end
  task automatic conclude();
    if (err_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic s, input logic [7:0] ad, input logic [7:0] dt);
    cpu.req(1'b1, s, ad, dt, 1'b0, 3'h0, 1'b0);
  endtask
  task automatic rd(input logic s, input logic [7:0] ad, input logic [7:0] ex, input logic e);
    cpu.req(1'b0, s, ad, 8'h00, 1'b0, 3'h0, 1'b0);
    cmp({7'h0, acc_err}, {7'h0, e});
    if (!e) cmp(rdata, ex);
  endtask
  // count cycles with the cpu held
  task automatic hold_len();
    n = 0;
    while (stall === 1'b1 && n < 20) begin
      n++;
      @(negedge clk);
    end
  endtask
  task automatic wait_idle();
    n = 0;
    while (busy === 1'b1 && n < 200) begin
      n++;
      @(negedge clk);
    end
    cmp({7'h0, busy}, 8'h00);
  endtask
  task automatic set_addr(input int x);
    wr(1'b0, DS_ADDR_LO, x[7:0]);
    wr(1'b0, DS_ADDR_HI, x[15:8]);
  endtask
  // unlock, optional gap, then strobe
  task automatic launch(input logic [1:0] m, input logic r, input int gap);
    wr(1'b1, ctl, {2'b00, m, r, 3'b100});
    repeat (gap) @(negedge clk);
    wr(1'b1, ctl, {2'b00, m, r, 3'b010});
  endtask
  // main sequence
  initial begin
    void'($urandom(32'hfef3d221));
    for (i = 0; i < 1024; i++) store[i] = ERASED;
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    por_b = 1'b1;
    for (i = 0; i < 3; i++) begin
      d = $urandom;
      wr(1'b0, sa[i], d);
      rd(1'b1, sa[i] - IO_OFS, d, 1'b0);
    end
    for (k = 0; k < 8; k++) begin
      v = $urandom;
      d[k] = v[0];
      cpu.req(1'b1, 1'b1, sa[0] - IO_OFS, 8'h00, 1'b1, k[2:0], v[0]);
      cpu.req(1'b0, 1'b1, sa[0] - IO_OFS, 8'h00, 1'b1, k[2:0], 1'b0);
      cmp({7'h0, bit_test}, {7'h0, v[0]});
    end
    rd(1'b0, DS_SCR0, d, 1'b0);
    cpu.req(1'b1, 1'b1, 8'h21, 8'h00, 1'b1, 3'h0, 1'b1);
    cmp({7'h0, acc_err}, 8'h01);
    rd(1'b1, 8'h40, 8'h00, 1'b1);
    d = $urandom;
    wr(1'b0, DS_TEMP, d);
    rd(1'b0, DS_TEMP, d, 1'b0);
    a = $urandom_range(1023);
    wr(1'b0, DS_ADDR_LO, a[7:0]);
    rd(1'b0, DS_TEMP, a[7:0], 1'b0);
    wr(1'b0, DS_ADDR_HI, a[15:8]);
    wr(1'b0, DS_TEMP, 8'h5a);
    rd(1'b1, 8'h21, a[7:0], 1'b0);
    rd(1'b0, DS_ADDR_HI, a[15:8], 1'b0);
    for (k = 0; k < 4; k++) begin
      a = $urandom_range(1023);
      d = $urandom;
      set_addr(a);
      wr(1'b0, DS_DATA, d);
      wr(1'b1, ctl, 8'h02);
      cmp({7'h0, busy}, 8'h00);
      launch(k[1:0], 1'b1, k % 3);
      hold_len();
      cmp(n[7:0], {5'h0, WRITE_STALL});
      cmp({7'h0, busy}, 8'h01);
      cmp({7'h0, irq}, 8'h00);
      wr(1'b1, ctl, {2'b00, ~k[1:0], 4'b1001});
      cmp({7'h0, stall}, 8'h00);
      rd(1'b1, ctl, {2'b00, k[1:0], 4'b1010}, 1'b0);
      wr(1'b0, DS_ADDR_HI, 8'h03 ^ a[15:8]);
      wait_idle();
      cmp({7'h0, irq}, 8'h01);
      store[a] = (k == 0) ? d : (k == 1) ? ERASED : (k == 2) ? (store[a] & d) : store[a];
      wr(1'b1, ctl, {2'b00, k[1:0], 4'b1001});
      hold_len();
      cmp(n[7:0], {5'h0, READ_STALL});
      rd(1'b0, DS_DATA, store[a], 1'b0);
      rd(1'b0, DS_ADDR_LO, a[7:0], 1'b0);
      rd(1'b0, DS_ADDR_HI, a[15:8], 1'b0);
    end
    launch(2'b00, 1'b0, 3);
    cmp({7'h0, busy}, 8'h00);
    a = $urandom_range(1023);
    d = $urandom;
    set_addr(a);
    wr(1'b0, DS_DATA, d);
    launch(2'b00, 1'b0, 0);
    rst_b = 1'b0;
    @(negedge clk);
    rst_b = 1'b1;
    cmp({7'h0, busy}, 8'h01);
    rd(1'b0, DS_DATA, DATA_RST, 1'b0);
    wait_idle();
    store[a] = d;
    set_addr(a);
    wr(1'b1, ctl, 8'h01);
    hold_len();
    rd(1'b0, DS_DATA, store[a], 1'b0);
    conclude();
  end
endmodule
